/* tb_top.sv */
// tb_top: self-checking bench for one three-wire serial channel.
// assumes tsio_channel, tsio_peer and the bound checker are compiled.
`timescale 1ns/1ps

module tb_top;
    logic i_clock, i_rst_n, done, cod, ood, tmr, ext, load, sdi, sck, sdo;
    tsio_pkg::tsio_cpu_req_type i_req;
    tsio_pkg::tsio_pins_type pins;
    logic [7:0] mode, csel, sdat, rxb, txb, tx;
    int seed = 79510;
    int num_errors = 0;
    int tests_run = 0;
    int cycles = 0;
    logic [7:0] exp_q[$];
    // released out line is pulled up; released clock line follows ext
    assign sck = pins.clk_oe_n ? ext : pins.clk_out;
    assign sdo = pins.data_oe_n ? 1'b1 : pins.data_out;
    tsio_channel dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_req(i_req),
        .o_mode_ctrl(mode), .o_clock_sel(csel), .o_shift_data(sdat),
        .o_done_request(done), .i_clk_open_drain(cod),
        .i_out_open_drain(ood), .i_timer_out(tmr),
        .i_serial_clock_pin(sck), .i_serial_in_pin(sdi), .o_pins(pins));
    tsio_peer peer (.i_sck(sck), .i_sdo(sdo), .o_sdi(sdi), .i_load(load),
        .i_tx(txb), .o_rx(rxb));
    // ********
    // clocks and tasks
    // ********
    initial
    begin
        i_clock = 1'b0;
        forever #20 i_clock = ~i_clock;
    end
    always @(posedge i_clock)
    begin
        cycles <= cycles + 1;
        if (cycles % 8 == 7) tmr <= ~tmr;
        if (cycles == 20000)
        begin
            num_errors++;
            summarize();
        end
    end
    task summarize;
        if (num_errors == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize
    task cyc;
        @(posedge i_clock);
        #1;
    endtask : cyc
    task chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // strobes k: mode, clock, shift write, shift read
    task put(input logic [3:0] k, input logic [2:0] p, input logic [7:0] d,
        input logic bw);
        i_req = {k, bw, p, d[0], d};
        cyc();
        i_req = '0;
        cyc();
    endtask : put
    task regs(input logic [7:0] md, input logic hi);
        put(4'b0100, 3'h0, {7'h00, hi}, 1'b0);
        put(4'b1000, 3'h0, md, 1'b0);
        chk(csel, {7'h00, hi});
        chk(mode, md);
    endtask : regs
    task frame(input logic [2:0] code, input logic rx);
        int w;
        txb = 8'($random(seed));
        tx = 8'($random(seed));
        cod = 1'($random(seed));
        ood = 1'($random(seed));
        exp_q.push_back(txb);
        regs({1'b1, 4'h0, rx, code[1:0]}, code[2]);
        load = 1'b1;
        cyc();
        load = 1'b0;
        if (rx) put(4'b0001, 3'h0, 8'h00, 1'b0);
        else put(4'b0010, 3'h0, tx, 1'b0);
        // last rise ends the wait, so the done pulse is not missed
        if (code == 3'b000)
        begin
            repeat (8)
            begin
                #160;
                ext = 1'b0;
                #160;
                ext = 1'b1;
            end
        end
        w = 0;
        while (done !== 1'b1 && w < 3000)
        begin
            cyc();
            w++;
        end
        chk({7'h00, done}, 8'h01);
        chk(sdat, exp_q.pop_front());
        if (!rx) chk(rxb, tx);
    endtask : frame
    // ********
    // main sequence
    // ********
    initial
    begin
        i_rst_n = 1'b0;
        i_req = '0;
        {cod, ood, tmr, load} = 4'h0;
        ext = 1'b1;
        txb = 8'h00;
        repeat (20) @(posedge i_clock);
        #1;
        i_rst_n = 1'b1;
        chk(mode, 8'h00);
        chk(csel, 8'h00);
        chk(sdat, 8'h00);
        chk({6'h00, pins.clk_oe_n, pins.data_oe_n}, 8'h03);
        put(4'b0100, 3'h0, 8'h01, 1'b1);
        chk(csel, 8'h01);
        put(4'b1000, 3'h7, 8'h01, 1'b1);
        chk(mode, 8'h80);
        for (int i = 0; i < 8; i++)
            if (i[2:1] != 2'b10) frame(i[2:0], 1'b0);
        frame(3'b000, 1'b1);
        frame(3'b110, 1'b1);
        regs(8'h80, 1'b1);
        put(4'b0010, 3'h0, 8'h5A, 1'b0);
        repeat (60) cyc();
        chk({7'h00, done}, 8'h00);
        regs(8'h00, 1'b0);
        chk({7'h00, pins.serial_active}, 8'h00);
        regs(8'h02, 1'b0);
        put(4'b0010, 3'h0, 8'h3C, 1'b0);
        chk(sdat, 8'h3C);
        regs(8'h82, 1'b0);
        put(4'b0001, 3'h0, 8'h00, 1'b0);
        repeat (40) cyc();
        chk({7'h00, pins.serial_active}, 8'h00);
        summarize();
    end
endmodule : tb_top

/* tsio_channel.sv */
// tsio_channel: one three-wire serial channel with its registers.
// assumes cpu strobes on i_clock; pins and timer output are asynchronous.
// Summary of operation
// RULE1: eight-bit frames over clock, out, in lines
// RULE2: frames go most significant bit first
// RULE3: shift out and in during same transfer
// RULE4: clock and out pins push-pull or open-drain
// RULE5: shift register eight bits, resets to zero
// RULE6: enabled access to shift register starts transfer
// RULE7: drive out from register, fill from input
// RULE8: software only makes the start access mid-transfer
// RULE9: clock select holds high bit only, resets zero
// RULE10: mode register enable, mode, low clock bits
// RULE11: disabled: register idle, counter cleared, pins ports
// RULE12: enabled: counter runs, unused pin stays port
// RULE13: mode zero write starts, mode one read
// RULE14: three bits choose clock source or divider
// RULE15: low clock bits change by whole writes
// RULE16: software writes zero to mode bits 3-6
// RULE17: timer clock routed internally, no pin setup
// RULE18: stop mode performs no transfers
// RULE19: shift register accessed only as bytes
// RULE20: shift on falling edge, sample on rising
// RULE21: stop after eight bits, raise done request
// RULE22: write while disabled never starts later
// RULE23: external source gives eight clock pulses
`timescale 1ns/1ps

module tsio_channel
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // cpu register port
    input wire tsio_pkg::tsio_cpu_req_type i_req,
    output logic [7:0] o_mode_ctrl,
    output logic [7:0] o_clock_sel,
    output logic [7:0] o_shift_data,
    output logic o_done_request,
    // pin output type settings
    input wire logic i_clk_open_drain,
    input wire logic i_out_open_drain,
    // clock sources
    input wire logic i_timer_out,
    // serial pins
    input wire logic i_serial_clock_pin,
    input wire logic i_serial_in_pin,
    output tsio_pkg::tsio_pins_type o_pins
);

    // ************************************************************
    // synchronisers
    // ************************************************************
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic ext_clk_prev;
    logic timer_prev;

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            // clock bit starts at its idle high level: no false edge
            sync_a <= 3'h1;
            sync_b <= 3'h1;
            ext_clk_prev <= 1'b1;
            timer_prev <= 1'b0;
        end
        else
        begin
            sync_a <= {i_timer_out, i_serial_in_pin, i_serial_clock_pin};
            sync_b <= sync_a;
            ext_clk_prev <= sync_b[0];
            timer_prev <= sync_b[2];
        end
    end

    logic ext_clk;
    logic in_bit;
    assign ext_clk = sync_b[0];
    assign in_bit = sync_b[1];

    // ************************************************************
    // registers
    // ************************************************************
    logic [7:0] mode_ctrl;
    logic [7:0] clock_sel;
    logic [7:0] next_mode;
    logic [7:0] next_clock;

    // bit writes touch one bit of the current value
    always_comb
    begin
        next_mode = i_req.wdata;
        next_clock = i_req.wdata;
        if (i_req.bit_wr)
        begin
            next_mode = mode_ctrl;
            next_mode[i_req.bit_pos] = i_req.bit_val;
            next_clock = clock_sel;
            next_clock[i_req.bit_pos] = i_req.bit_val;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            mode_ctrl <= tsio_pkg::REG_RESET; // [RULE10]
            clock_sel <= tsio_pkg::REG_RESET; // [RULE9]
        end
        else
        begin
            // bits 3-6 read zero regardless of what software writes
            if (i_req.mode_wr)
                mode_ctrl <= next_mode & tsio_pkg::MODE_CTRL_MASK; // [RULE10]
            if (i_req.clock_wr)
                clock_sel <= next_clock & tsio_pkg::CLOCK_SEL_MASK; // [RULE9]
        end
    end

    logic enable;
    logic rx_only;
    tsio_pkg::tsio_clk_sel_type clk_sel;
    assign enable = mode_ctrl[tsio_pkg::ENABLE_POS];
    assign rx_only = mode_ctrl[tsio_pkg::MODE_POS];
    assign clk_sel = tsio_pkg::tsio_clk_sel_type'({
        clock_sel[tsio_pkg::CLK_HIGH_POS],
        mode_ctrl[tsio_pkg::CLK_MID_POS],
        mode_ctrl[tsio_pkg::CLK_LOW_POS]}); // [RULE14]

    // ************************************************************
    // clock source: edge pulses at the selected rate
    // ************************************************************
    logic internal_clk;
    logic [tsio_pkg::DIV_WIDTH-1:0] div_count;
    logic [tsio_pkg::DIV_WIDTH-1:0] div_half;
    logic div_tick;

    always_comb
    begin
        unique case (clk_sel)
            tsio_pkg::TSIO_CLK_DIV8: div_half = tsio_pkg::HALF_DIV8;
            tsio_pkg::TSIO_CLK_DIV16: div_half = tsio_pkg::HALF_DIV16;
            tsio_pkg::TSIO_CLK_DIV32: div_half = tsio_pkg::HALF_DIV32;
            default: div_half = tsio_pkg::HALF_DIV64;
        endcase
    end

    assign div_tick = (div_count == div_half);

    // ************************************************************
    // transfer engine
    // ************************************************************
    tsio_pkg::tsio_state_type state;
    logic [7:0] shift_reg;
    logic [2:0] bit_count;
    logic out_latch;
    logic done_request;
    logic fall_edge;
    logic rise_edge;
    logic start;

    // timer and divider clocks are both made here and driven out
    assign internal_clk = clk_sel != tsio_pkg::TSIO_CLK_EXT;
    // prohibited codes give no edges at all
    always_comb
    begin
        fall_edge = 1'b0;
        rise_edge = 1'b0;
        if (state != tsio_pkg::TSIO_IDLE)
        begin
            unique case (clk_sel)
                tsio_pkg::TSIO_CLK_EXT:
                begin
                    fall_edge = ext_clk_prev && !ext_clk; // [RULE23]
                    rise_edge = !ext_clk_prev && ext_clk;
                end
                tsio_pkg::TSIO_CLK_TIMER:
                begin
                    // timer level steers an internal clock, no pin needed
                    fall_edge = !timer_prev && sync_b[2]; // [RULE17]
                    rise_edge = timer_prev && !sync_b[2];
                end
                tsio_pkg::TSIO_CLK_BAD4, tsio_pkg::TSIO_CLK_BAD5:
                begin
                    fall_edge = 1'b0;
                    rise_edge = 1'b0;
                end
                default:
                begin
                    fall_edge = div_tick && state == tsio_pkg::TSIO_HIGH;
                    rise_edge = div_tick && state == tsio_pkg::TSIO_LOW;
                end
            endcase
        end
    end

    // a write made while disabled is just stored, never remembered
    assign start = enable && state == tsio_pkg::TSIO_IDLE &&
        (rx_only ? i_req.shift_rd : i_req.shift_wr); // [RULE6] [RULE13] [RULE22]

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
            div_count <= '0;
        else if (state == tsio_pkg::TSIO_IDLE || div_tick)
            div_count <= '0;
        else
            div_count <= div_count + 1'b1;
    end

    // bit count sits at zero while disabled and between frames
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state <= tsio_pkg::TSIO_IDLE;
            bit_count <= tsio_pkg::BIT_COUNT_ZERO;
        end
        else if (!enable)
        begin
            state <= tsio_pkg::TSIO_IDLE; // [RULE11] [RULE18]
            bit_count <= tsio_pkg::BIT_COUNT_ZERO;
        end
        else
        begin
            unique case (state)
                tsio_pkg::TSIO_IDLE:
                    if (start)
                        state <= tsio_pkg::TSIO_HIGH; // [RULE12]
                tsio_pkg::TSIO_HIGH:
                    if (fall_edge)
                        state <= tsio_pkg::TSIO_LOW;
                tsio_pkg::TSIO_LOW:
                    if (rise_edge)
                    begin
                        bit_count <= bit_count + 1'b1;
                        if (bit_count == tsio_pkg::BIT_COUNT_LAST)
                            state <= tsio_pkg::TSIO_IDLE; // [RULE21]
                        else
                            state <= tsio_pkg::TSIO_HIGH;
                    end
            endcase
        end
    end

    // first falling edge puts out bit 7; sample lands in bit 0 on rise
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            shift_reg <= tsio_pkg::REG_RESET; // [RULE5]
            out_latch <= 1'b1;
        end
        else if (i_req.shift_wr && state == tsio_pkg::TSIO_IDLE)
            shift_reg <= i_req.wdata;
        else if (enable && fall_edge)
            out_latch <= shift_reg[7]; // [RULE2] [RULE7] [RULE20]
        else if (enable && rise_edge)
            shift_reg <= {shift_reg[6:0], in_bit}; // [RULE3] [RULE7] [RULE20]
    end

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
            done_request <= 1'b0;
        else
            done_request <= enable && rise_edge &&
                state == tsio_pkg::TSIO_LOW &&
                bit_count == tsio_pkg::BIT_COUNT_LAST; // [RULE21] [RULE1]
    end

    // ************************************************************
    // pins and register read-back
    // ************************************************************
    logic drive_clk;
    logic clk_level;
    logic drive_out;

    assign drive_clk = enable && internal_clk;
    assign clk_level = state != tsio_pkg::TSIO_LOW;
    assign drive_out = enable && !rx_only; // [RULE12] [RULE13]

    // open drain only ever pulls low; a high level releases the pin
    always_comb
    begin
        o_pins.clk_out = clk_level;
        o_pins.clk_oe_n = !drive_clk ||
            (i_clk_open_drain && clk_level); // [RULE4]
        o_pins.data_out = out_latch;
        o_pins.data_oe_n = !drive_out ||
            (i_out_open_drain && out_latch); // [RULE4]
        o_pins.serial_active = state != tsio_pkg::TSIO_IDLE;
    end

    assign o_mode_ctrl = mode_ctrl;
    assign o_clock_sel = clock_sel;
    assign o_shift_data = shift_reg;
    assign o_done_request = done_request;

endmodule : tsio_channel

/* tsio_channel_assertions.sv */
// tsio_chk: port-level checks of one three-wire serial channel.
// assumes it is bound onto tsio_channel; one clock domain.
`timescale 1ns/1ps

module tsio_chk
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // cpu side
    input wire tsio_pkg::tsio_cpu_req_type i_req,
    input wire logic [7:0] o_mode_ctrl,
    input wire logic [7:0] o_clock_sel,
    input wire logic [7:0] o_shift_data,
    input wire logic o_done_request,
    // pins
    input wire logic i_clk_open_drain,
    input wire logic i_out_open_drain,
    input wire logic i_timer_out,
    input wire logic i_serial_clock_pin,
    input wire logic i_serial_in_pin,
    input wire tsio_pkg::tsio_pins_type o_pins
);
    // ********
    // checks
    // ********
    logic en;
    logic act;
    logic [2:0] sel;
    assign en = o_mode_ctrl[7];
    assign act = o_pins.serial_active;
    assign sel = {o_clock_sel[0], o_mode_ctrl[1:0]};
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    mode_write_a: assert property (i_req.mode_wr && !i_req.bit_wr
        |=> o_mode_ctrl == ($past(i_req.wdata) & 8'h87))
        else $error("mode register write lost");
    clk_write_a: assert property (i_req.clock_wr && !i_req.bit_wr
        |=> o_clock_sel == {7'h00, $past(i_req.wdata[0])})
        else $error("clock select write lost");
    idle_pins_a: assert property (!en && !$past(en)
        |-> o_pins.clk_oe_n && o_pins.data_oe_n && !act)
        else $error("disabled channel still active");
    rx_out_free_a: assert property (en && o_mode_ctrl[2]
        |-> o_pins.data_oe_n) else $error("out pin driven in rx mode");
    tx_start_a: assert property (en && !o_mode_ctrl[2] && !act
        && i_req.shift_wr |=> act) else $error("write did not start");
    rx_start_a: assert property (en && o_mode_ctrl[2] && !act
        && i_req.shift_rd |=> act) else $error("read did not start");
    dead_start_a: assert property (!en && !act
        && (i_req.shift_wr || i_req.shift_rd) |=> !act)
        else $error("disabled access started a frame");
    div8_low_a: assert property ($fell(o_pins.clk_out)
        && sel == 3'b010 |-> !o_pins.clk_out [*4] ##1 o_pins.clk_out)
        else $error("divide by 8 low phase wrong");
    done_pulse_a: assert property (o_done_request
        |=> !o_done_request) else $error("done longer than one cycle");
    ext_clk_a: assert property (sel == 3'b000
        |-> o_pins.clk_oe_n) else $error("clock pin driven on external");
    od_low_a: assert property (i_clk_open_drain && !o_pins.clk_oe_n
        |-> !o_pins.clk_out) else $error("open drain clock drove high");
    cover property (o_done_request && o_mode_ctrl[2]);
    cover property (o_done_request && sel == 3'b000);
    cover property ($fell(act) && !en);
endmodule : tsio_chk

bind tsio_channel tsio_chk chk (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_req(i_req), .o_mode_ctrl(o_mode_ctrl), .o_clock_sel(o_clock_sel),
    .o_shift_data(o_shift_data), .o_done_request(o_done_request),
    .i_clk_open_drain(i_clk_open_drain), .i_out_open_drain(i_out_open_drain),
    .i_timer_out(i_timer_out), .i_serial_clock_pin(i_serial_clock_pin),
    .i_serial_in_pin(i_serial_in_pin), .o_pins(o_pins));

/* tsio_peer.sv */
// tsio_peer: clocked serial peripheral on the far side of the channel.
// assumes wire levels of the clock and data lines as its inputs.
`timescale 1ns/1ps

module tsio_peer
(
    // serial lines
    input wire logic i_sck,
    input wire logic i_sdo,
    output logic o_sdi,
    // bench side
    input wire logic i_load,
    input wire logic [7:0] i_tx,
    output logic [7:0] o_rx
);
    // ********
    // shifting
    // ********
    logic [7:0] sh = 8'h00;
    int n = 8;
    initial o_sdi = 1'b0;
    // answers late, like a slow part; junk once the byte is out
    always @(negedge i_sck or posedge i_load)
    begin
        if (i_load)
        begin
            sh = i_tx;
            n = 0;
            o_sdi <= ~o_sdi;
        end
        else if (n < 8)
        begin
            o_sdi <= #30 sh[7];
            sh = {sh[6:0], 1'b0};
            n++;
        end
        else
            o_sdi <= #30 ~o_sdi;
    end
    always @(posedge i_sck) o_rx <= {o_rx[6:0], i_sdo};
endmodule : tsio_peer

/* tsio_pkg.sv */
// tsio_pkg: constants and carrier types for one three-wire serial channel.
// assumes a byte-wide cpu register port with per-register select strobes.
package tsio_pkg;

    // ************************************************************
    // register offsets and fields
    // ************************************************************
    localparam logic [31:0] MODE_CTRL_0_ADDR = 32'hFFFFF2A2;
    localparam logic [31:0] CLOCK_SEL_0_ADDR = 32'hFFFFF2A4;
    localparam logic [31:0] MODE_CTRL_1_ADDR = 32'hFFFFF2B2;
    localparam logic [31:0] CLOCK_SEL_1_ADDR = 32'hFFFFF2B4;
    localparam logic [31:0] MODE_CTRL_2_ADDR = 32'hFFFFF2C2;
    localparam logic [31:0] CLOCK_SEL_2_ADDR = 32'hFFFFF2C4;

    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int ENABLE_POS = 7;
    localparam int MODE_POS = 2;
    localparam int CLK_MID_POS = 1;
    localparam int CLK_LOW_POS = 0;
    localparam int CLK_HIGH_POS = 0;
    localparam logic [7:0] MODE_CTRL_MASK = 8'h87;
    localparam logic [7:0] CLOCK_SEL_MASK = 8'h01;

    localparam logic [2:0] BIT_COUNT_LAST = 3'h7;
    localparam logic [2:0] BIT_COUNT_ZERO = 3'h0;

    // ************************************************************
    // clock selection codes and divider counts
    // ************************************************************
    typedef enum logic [2:0] {
        TSIO_CLK_EXT = 3'b000,
        TSIO_CLK_TIMER = 3'b001,
        TSIO_CLK_DIV8 = 3'b010,
        TSIO_CLK_DIV16 = 3'b011,
        TSIO_CLK_BAD4 = 3'b100,
        TSIO_CLK_BAD5 = 3'b101,
        TSIO_CLK_DIV32 = 3'b110,
        TSIO_CLK_DIV64 = 3'b111
    } tsio_clk_sel_type;

    localparam int DIV_WIDTH = 6;
    localparam logic [5:0] HALF_DIV8 = 6'h03;
    localparam logic [5:0] HALF_DIV16 = 6'h07;
    localparam logic [5:0] HALF_DIV32 = 6'h0F;
    localparam logic [5:0] HALF_DIV64 = 6'h1F;

    typedef enum logic [1:0] {
        TSIO_IDLE = 2'b00,
        TSIO_LOW = 2'b01,
        TSIO_HIGH = 2'b10
    } tsio_state_type;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic mode_wr;
        logic clock_wr;
        logic shift_wr;
        logic shift_rd;
        logic bit_wr;
        logic [2:0] bit_pos;
        logic bit_val;
        logic [7:0] wdata;
    } tsio_cpu_req_type;

    typedef struct packed {
        logic clk_out;
        logic clk_oe_n;
        logic data_out;
        logic data_oe_n;
        logic serial_active;
    } tsio_pins_type;

endpackage : tsio_pkg
